/* File: logic/debug_bp_pkg.sv */
// Package for the debug breakpoint unit: register map, field layout, types.
// Assumes an AXI4-Lite master with 32-bit data and one aligned word per register.
package debug_bp_pkg;
  localparam int unsigned NUM_SLOTS = 4;
  localparam logic [5:0] OFS_BP_ADDR0 = 6'h00;
  localparam logic [5:0] OFS_DEBUG_STATUS = 6'h10;
  localparam logic [5:0] OFS_DEBUG_CONTROL = 6'h14;
  localparam logic [5:0] OFS_CORE_FLAGS = 6'h18;
  // Control register field positions
  localparam int unsigned CTL_LOCAL_EN0 = 0;
  localparam int unsigned CTL_EXACT_PER_TASK = 8;
  localparam int unsigned CTL_EXACT_ALL = 9;
  localparam int unsigned CTL_GUARD = 13;
  localparam int unsigned CTL_USAGE0 = 16;
  localparam int unsigned CTL_SIZE0 = 18;
  // Status register field positions
  localparam int unsigned STS_GUARD_HIT = 13;
  localparam int unsigned STS_STEP_HIT = 14;
  localparam int unsigned STS_SWITCH_HIT = 15;
  // Reset values
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0400;
  localparam logic [31:0] STATUS_RESET = 32'hFFFF_0FF0;
  localparam logic [31:0] STATUS_WRITE_MASK = 32'h0000_E00F;
  localparam logic [31:0] CONTROL_WRITE_MASK = 32'hFFFF_23FF;
  // Usage and size encodings
  localparam logic [1:0] USAGE_EXEC = 2'h0;
  localparam logic [1:0] USAGE_WRITE = 2'h1;
  localparam logic [1:0] USAGE_RDWR = 2'h3;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] ACC_ONE = 4'h1;

  // One access presented by the execution core
  typedef struct packed {
    logic valid;
    logic is_fetch;
    logic is_write;
    logic [3:0] bytes;
    logic [31:0] addr;
  } core_access_t;

  // Events and flags from the core
  typedef struct packed {
    logic task_switch;
    logic new_task_trap;
    logic step_done;
    logic step_trap_flag;
    logic resume_flag;
    logic dbg_reg_access;
  } core_event_t;

  // Requests to the exception sequencer
  typedef struct packed {
    logic raise;
    logic is_fault;
    logic hold_next;
  } debug_req_t;
endpackage : debug_bp_pkg

/* File: logic/debug_breakpoint_unit.sv */
// Breakpoint enables, match detection and sticky debug status.
// Assumes the core stalls on hold_next and takes a raise the cycle it is driven.
// Overview of operation
// - Exact data matching is always done, whatever the exact-match bits hold.
// - Core holds the next instruction until data transfers of the current one finish.
// - A task switch clears the per-task exact-match bit.
// - The all-task exact-match bit survives a task switch.
// - Execution breakpoints are reported precisely at the matching instruction.
// - A slot is enabled if its all-task or per-task enable is set.
// - An enabled slot condition raises the debug exception, vector 1.
// - A task switch clears all four per-task breakpoint enables.
// - A task switch leaves the four all-task enables unchanged.
// - Status has one flag per cause: four slots, step, switch, guard.
// - Status flags are set only by hardware and cleared only by software; here a software write of 1 to a flag also sets it.
// - Four hit flags map onto the four slots by address, size and usage.
// - Execution breakpoints raise a fault; data breakpoints raise a trap.
// - On any enabled hit, flag every slot matching then, even disabled ones.
// - Guarded access sets the guard hit flag and clears the guard bit.
// - The step flag is set when the step trap flag causes the exception.
// - Switch into a trapping task sets the switch flag and traps first.
// - The resume flag suppresses execution breakpoints at the return address.
// - Usage 00 fetch, 01 writes, 11 reads and writes; 10 undefined.
// - Size 00 one byte, 01 two aligned, 11 four aligned; 10 undefined.
// - A data access partly inside an enabled slot field causes a trap.
// - With the guard bit set, debug register access faults instead.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
module debug_breakpoint_unit
  import debug_bp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Execution core
  input wire core_access_t core_access,
  input wire core_event_t core_event,
  input wire logic data_busy,
  output debug_req_t debug_req
);

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  logic [31:0] bp_address_regs [NUM_SLOTS];
  logic [31:0] debug_control_reg;
  logic [31:0] debug_status_reg;

  // Register bus state
  wr_state_t wr_state;
  logic aw_held;
  logic w_held;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic rd_take;

  // Per-slot match results
  logic [NUM_SLOTS-1:0] slot_match;
  logic [NUM_SLOTS-1:0] slot_enabled;
  logic [NUM_SLOTS-1:0] bp_hit_flags;
  logic any_enabled_hit;
  logic exec_hit;
  logic guard_fault;
  logic step_event;
  logic switch_event;
  logic wr_fire;
  logic [31:0] wr_mask;
  logic [31:0] status_set;

  // Byte-lane mask from strobes
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  // Word decode of a register offset; the two low address bits are ignored
  function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] ofs);
    reg_hit = addr[5:2] == ofs[5:2];
  endfunction : reg_hit

  // Writable map: address, status and control registers only; the flag view is read only
  function automatic logic write_ok(input logic [5:0] addr);
    write_ok = addr < OFS_CORE_FLAGS;
  endfunction : write_ok

  // Access type test; usage 10 is reserved and never matches
  function automatic logic usage_ok(input logic [1:0] usage, input core_access_t acc);
    case (usage)
      USAGE_EXEC:
        usage_ok = acc.is_fetch;
      USAGE_WRITE:
        usage_ok = !acc.is_fetch && acc.is_write;
      USAGE_RDWR:
        usage_ok = !acc.is_fetch;
      default:
        usage_ok = 1'b0;
    endcase
  endfunction : usage_ok

  // Aligned field test against one access; overlap, not containment
  // Overlap lets a misaligned access that straddles the field still hit
  function automatic logic slot_hit(input logic [31:0] bp, input logic [1:0] size,
                                    input logic [31:0] addr, input logic [3:0] bytes);
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] blo;
    logic [31:0] bhi;
    lo = addr;
    hi = addr + {28'h000_0000, bytes} - 32'h0000_0001;
    blo = bp;
    if (size == SIZE_WORD)
      blo[0] = 1'b0;
    else if (size == SIZE_DWORD)
      blo[1:0] = 2'b00;
    bhi = blo + ((size == SIZE_DWORD) ? 32'h0000_0003 :
                 (size == SIZE_WORD) ? 32'h0000_0001 : 32'h0000_0000);
    slot_hit = (lo <= bhi) && (hi >= blo);
  endfunction : slot_hit

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SLOTS; gi++)
    begin : g_slot
      logic [1:0] usage;
      logic [1:0] size;
      logic type_ok;
      logic exec_match;
      logic data_match;
      assign usage = debug_control_reg[CTL_USAGE0 + 4*gi +: 2];
      assign size = debug_control_reg[CTL_SIZE0 + 4*gi +: 2];
      // Usage 10 never matches
      assign type_ok = usage_ok(usage, core_access);
      // Fetch matches only the first byte; the resume flag masks it
      assign exec_match = !core_event.resume_flag &&
                          core_access.addr == bp_address_regs[gi];
      assign data_match = slot_hit(bp_address_regs[gi], size, core_access.addr,
                                   core_access.bytes);
      assign slot_match[gi] = core_access.valid && type_ok &&
                              (core_access.is_fetch ? exec_match : data_match);
      assign slot_enabled[gi] = debug_control_reg[CTL_LOCAL_EN0 + 2*gi] |
                                debug_control_reg[CTL_LOCAL_EN0 + 2*gi + 1];
    end
  endgenerate

  assign any_enabled_hit = |(slot_match & slot_enabled);
  // Disabled slots are flagged alongside any real hit
  assign bp_hit_flags = any_enabled_hit ? slot_match : '0;
  assign exec_hit = any_enabled_hit && core_access.is_fetch;
  assign guard_fault = core_event.dbg_reg_access && debug_control_reg[CTL_GUARD];
  assign step_event = core_event.step_done && core_event.step_trap_flag;
  assign switch_event = core_event.task_switch && core_event.new_task_trap;
  assign wr_fire = wr_state == WR_IDLE && aw_held && w_held;
  assign wr_mask = lane_mask(w_strb);
  assign rd_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  // Hardware set vector; flags only ever accumulate from this side
  assign status_set = {16'h0000, switch_event, step_event, guard_fault, 9'h000,
                       bp_hit_flags};

  // Exception request; exact data reporting regardless of exact-match bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      debug_req <= '0;
    else
    begin
      debug_req.raise <= any_enabled_hit || guard_fault || step_event || switch_event;
      debug_req.is_fault <= exec_hit || guard_fault;
      debug_req.hold_next <= data_busy;
      // Core waits on hold_next, so data traps land right after the instruction
      // Fetch hits are checked before issue, so they are always precise
    end
  end

  // Status: hardware sets win over a same-cycle software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      debug_status_reg <= STATUS_RESET;
    else
    begin
      if (wr_fire && reg_hit(aw_addr, OFS_DEBUG_STATUS))
        debug_status_reg <= (debug_status_reg & ~(STATUS_WRITE_MASK & wr_mask)) |
                            (w_data & STATUS_WRITE_MASK & wr_mask) | status_set;
      else
        debug_status_reg <= debug_status_reg | status_set;
    end
  end

  // Control register with task-switch and guard side effects
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      debug_control_reg <= CONTROL_RESET;
    else
    begin
      logic [31:0] next_control;
      next_control = debug_control_reg;
      if (wr_fire && reg_hit(aw_addr, OFS_DEBUG_CONTROL))
        next_control = (debug_control_reg & ~(CONTROL_WRITE_MASK & wr_mask)) |
                       (w_data & CONTROL_WRITE_MASK & wr_mask);
      // Only per-task state is dropped; all-task enables and exact bit survive
      if (core_event.task_switch)
      begin
        for (int i = 0; i < NUM_SLOTS; i++)
          next_control[CTL_LOCAL_EN0 + 2*i] = 1'b0;
        next_control[CTL_EXACT_PER_TASK] = 1'b0;
      end
      if (guard_fault)
        next_control[CTL_GUARD] = 1'b0;
      debug_control_reg <= next_control;
    end
  end

  // Breakpoint address registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NUM_SLOTS; i++)
        bp_address_regs[i] <= '0;
    end
    else if (wr_fire && aw_addr < OFS_DEBUG_STATUS)
      bp_address_regs[aw_addr[3:2]] <= (bp_address_regs[aw_addr[3:2]] & ~wr_mask) |
                                       (w_data & wr_mask);
  end

  // Write address capture; held until the write is done
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      if (wr_fire)
        aw_held <= 1'b0;
      else if (wr_state == WR_IDLE && s_axi_awvalid && !aw_held && !s_axi_awready)
      begin
        s_axi_awready <= 1'b1;
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[5:2], 2'b00};
      end
    end
  end

  // Write data capture; held until the write is done
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= 1'b0;
      if (wr_fire)
        w_held <= 1'b0;
      else if (wr_state == WR_IDLE && s_axi_wvalid && !w_held && !s_axi_wready)
      begin
        s_axi_wready <= 1'b1;
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Write response once address and data are both held
  // Waiting for both halves lets address and data arrive in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state <= WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      case (wr_state)
        WR_IDLE:
        begin
          if (wr_fire)
          begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= write_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            wr_state <= WR_RESP;
          end
        end
        WR_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wr_state <= WR_IDLE;
          end
        end
        default:
          wr_state <= WR_IDLE;
      endcase
    end
  end

  // Read handshake; one read at a time, answer one cycle after the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end
    else
    begin
      s_axi_arready <= rd_take;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (rd_take)
        s_axi_rvalid <= 1'b1;
    end
  end

  // Read data, latched with the handshake and held until the next read
  // The core flag view is read live, so software sees the level at read time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr < OFS_DEBUG_STATUS)
        s_axi_rdata <= bp_address_regs[s_axi_araddr[3:2]];
      else if (reg_hit(s_axi_araddr, OFS_DEBUG_STATUS))
        s_axi_rdata <= debug_status_reg;
      else if (reg_hit(s_axi_araddr, OFS_DEBUG_CONTROL))
        s_axi_rdata <= debug_control_reg;
      else if (reg_hit(s_axi_araddr, OFS_CORE_FLAGS))
        s_axi_rdata <= {29'h0000_0000, core_event.resume_flag,
                        core_event.step_trap_flag, data_busy};
      else
      begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end
  end

endmodule : debug_breakpoint_unit

/* File: sim/debug_breakpoint_unit_properties.sv */
// Checker of debug requests against core events.
// Assumes it is bound to the top module.
module bp_checker
  import debug_bp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Core side
  input wire core_access_t core_access,
  input wire core_event_t core_event,
  input wire logic data_busy,
  input wire debug_req_t debug_req
);
  timeunit 1ns;
  timeprecision 100ps;
  logic no_evt;
  logic idle;
  logic fault_cause;
  logic data_only;
  assign no_evt = !core_event.task_switch && !core_event.step_done && !core_event.dbg_reg_access;
  assign idle = no_evt && !core_access.valid;
  assign fault_cause = (core_access.valid && core_access.is_fetch) || core_event.dbg_reg_access;
  assign data_only = no_evt && core_access.valid && !core_access.is_fetch;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_hold_tracks_busy: assert property (1'b1 |=> debug_req.hold_next == $past(data_busy))
    else $error("hold_next does not follow data_busy");
  a_quiet_no_cause: assert property (idle |=> !debug_req.raise)
    else $error("raise without a cause");
  a_step_trap_raise: assert property (core_event.step_done && core_event.step_trap_flag
    && !core_access.valid |=> debug_req.raise && !debug_req.is_fault)
    else $error("step trap not raised");
  a_switch_trap_raise: assert property (core_event.task_switch && core_event.new_task_trap
    && !core_access.valid |=> debug_req.raise && !debug_req.is_fault)
    else $error("switch trap not raised");
  a_plain_switch_quiet: assert property (core_event.task_switch && !core_event.new_task_trap
    && !core_event.step_done && !core_event.dbg_reg_access && !core_access.valid
    |=> !debug_req.raise)
    else $error("raise on plain switch");
  a_resume_blocks_exec: assert property (no_evt && core_access.valid && core_access.is_fetch
    && core_event.resume_flag |=> !debug_req.raise)
    else $error("fetch match not suppressed");
  a_fault_from_fetch: assert property (debug_req.raise && debug_req.is_fault
    |-> $past(fault_cause))
    else $error("fault without fetch or guarded access");
  a_data_is_trap: assert property (debug_req.raise && $past(data_only)
    |-> !debug_req.is_fault)
    else $error("data match raised as fault");
endmodule : bp_checker

bind debug_breakpoint_unit bp_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .core_access(core_access), .core_event(core_event), .data_busy(data_busy),
  .debug_req(debug_req));

/* File: sim/core_model.sv */
// Model of the execution core: one access and one event word per call.
// Assumes calls start right after a rising edge.
module core_model
  import debug_bp_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Toward the unit
  output core_access_t core_access,
  output core_event_t core_event,
  output logic data_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    core_access = '0;
    core_event = '0;
    data_busy = 1'b0;
  end
  // Released address lines show the inverse, never a stale match
  task automatic cycle(input core_access_t a, input core_event_t e);
    core_access_t rel;
    rel = a;
    rel.valid = 1'b0;
    rel.addr = ~a.addr;
    @(posedge aclk);
    core_access <= a;
    core_event <= e;
    data_busy <= a.valid && !a.is_fetch;
    @(posedge aclk);
    core_access <= rel;
    core_event <= '0;
    data_busy <= 1'b0;
  endtask : cycle
endmodule : core_model

/* File: sim/tb_debug_breakpoint_unit.sv */
// Testbench of the breakpoint unit over AXI4-Lite and the core model.
// Assumes the package and the checker are compiled first.
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_debug_breakpoint_unit
  import debug_bp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] awaddr = '0;
  logic [5:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  core_access_t acc;
  core_event_t ev;
  logic busy;
  debug_req_t req;
  int bad_count = 0;
  int n_tests = 0;
  debug_breakpoint_unit DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_access(acc), .core_event(ev), .data_busy(busy), .debug_req(req));
  core_model u_core (.aclk(aclk), .core_access(acc), .core_event(ev), .data_busy(busy));
  initial
  begin
    forever #25 aclk = ~aclk;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic guard(input logic ok);
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("[ERR] %0t bus timeout", $time);
      complete_run();
    end
  endtask : guard
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    guard(bvalid);
    `CHK(bresp, er)
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b0;
    guard(rvalid);
    `CHK({rdata, rresp}, {d, er})
  endtask : rd
  function automatic core_access_t mk(input logic f, input logic w, input logic [31:0] a);
    return {1'b1, f, w, ACC_ONE, a};
  endfunction : mk
  // Raise is looked at one cycle after the causing cycle
  task automatic ev1(input core_access_t a, input core_event_t e, input logic r, input logic f);
    u_core.cycle(a, e);
    #1;
    `CHK({req.raise, req.is_fault & r}, {r, f})
  endtask : ev1
  task automatic t_regs;
    rd(OFS_DEBUG_CONTROL, CONTROL_RESET, RESP_OKAY);
    rd(OFS_DEBUG_STATUS, STATUS_RESET, RESP_OKAY);
    rd(6'h3c, 32'h0000_0000, RESP_SLVERR);
    wr(OFS_CORE_FLAGS, 32'h0000_0000, RESP_SLVERR);
    $display("regs done");
  endtask : t_regs
  task automatic t_exec;
    wr(OFS_BP_ADDR0, 32'h0000_1000, RESP_OKAY);
    wr(6'h04, 32'h0000_1000, RESP_OKAY);
    wr(OFS_DEBUG_CONTROL, 32'h0000_0002, RESP_OKAY);
    ev1(mk(1'b1, 1'b0, 32'h0000_1000), '0, 1'b1, 1'b1);
    rd(OFS_DEBUG_STATUS, 32'hffff_0ff3, RESP_OKAY);
    ev1(mk(1'b1, 1'b0, 32'h0000_1000), 6'h02, 1'b0, 1'b0);
    rd(OFS_DEBUG_STATUS, 32'hffff_0ff3, RESP_OKAY);
    wr(OFS_DEBUG_STATUS, 32'h0000_0000, RESP_OKAY);
    rd(OFS_DEBUG_STATUS, STATUS_RESET, RESP_OKAY);
    $display("exec done");
  endtask : t_exec
  task automatic t_data;
    logic [31:0] w;
    w = 32'h0500_0332;
    wr(6'h08, 32'h0000_0105, RESP_OKAY);
    wr(OFS_DEBUG_CONTROL, w, RESP_OKAY);
    ev1(mk(1'b0, 1'b0, 32'h0000_0104), '0, 1'b0, 1'b0);
    ev1(mk(1'b0, 1'b1, 32'h0000_0104), '0, 1'b1, 1'b0);
    ev1(mk(1'b0, 1'b1, 32'h0000_0106), '0, 1'b0, 1'b0);
    rd(OFS_DEBUG_STATUS, 32'hffff_0ff4, RESP_OKAY);
    ev1('0, 6'h20, 1'b0, 1'b0);
    w = ((w & CONTROL_WRITE_MASK) | (CONTROL_RESET & ~CONTROL_WRITE_MASK)) & ~32'h0000_0155;
    rd(OFS_DEBUG_CONTROL, w, RESP_OKAY);
    wr(OFS_DEBUG_STATUS, 32'h0000_0000, RESP_OKAY);
    $display("data done");
  endtask : t_data
  task automatic t_events;
    wr(OFS_DEBUG_CONTROL, 32'h0000_2000, RESP_OKAY);
    ev1('0, 6'h01, 1'b1, 1'b1);
    rd(OFS_DEBUG_CONTROL, CONTROL_RESET, RESP_OKAY);
    ev1('0, 6'h01, 1'b0, 1'b0);
    ev1('0, 6'h0c, 1'b1, 1'b0);
    ev1('0, 6'h30, 1'b1, 1'b0);
    rd(OFS_DEBUG_STATUS, 32'hffff_eff0, RESP_OKAY);
    $display("events done");
  endtask : t_events
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_exec();
    t_data();
    t_events();
    complete_run();
  end
endmodule : tb_debug_breakpoint_unit
